// >>> verilog/fci_top.sv
`timescale 1ns/1ps
module fci_top (
	// Clock and reset
	input  wire logic                       REF_CLK,
	input  wire logic                       SYS_RST,
	// Register port
	input  wire logic [7:0]                 REG_ADDR,
	input  wire logic [31:0]                REG_WDATA,
	input  wire logic                       REG_WR,
	input  wire logic                       REG_RD,
	output logic [31:0]                     REG_RDATA,
	// Flash bus
	output logic                            FL_CE_N,
	output logic                            FL_OE_N,
	output logic                            FL_WE_N,
	output logic [fci_pkg::ADDR_W-1:0]      FL_ADDR,
	output logic [fci_pkg::DQ_W-1:0]        FL_DQ_O,
	output logic                            FL_DQ_OE,
	input  wire logic [fci_pkg::DQ_W-1:0]   FL_DQ_I,
	// Flash control and supplies
	output logic                            FL_RP_N,
	output logic                            FL_RP_HV_EN,
	output logic                            FL_VPP_EN,
	input  wire logic                       FL_READY_BUSY_N_N
);

	fci_cyc_if cyc ();

	fci_pkg::fci_seq_e          seq;
	fci_pkg::fci_op_s           dec;
	fci_pkg::fci_op_s           cur;
	logic [fci_pkg::ADDR_W-1:0] flash_addr;
	logic [fci_pkg::DQ_W-1:0]   prog_data;
	logic [fci_pkg::DQ_W-1:0]   rd_data;
	logic [3:0]                 last_op;
	logic                       refused;
	logic                       pd_req;
	logic [7:0]                 pd_cnt;
	logic [7:0]                 wake_cnt;
	logic                       ryby_s1;
	logic                       ryby_s2;
	logic                       op_write;
	logic                       pins_write;
	logic                       stat_write;
	logic                       rp_ok;
	logic                       accept;
	logic                       refuse_evt;

	// ----------------------------------------
	// Operation decode
	// ----------------------------------------
	// RULE22: only defined codes are ever emitted
	always_comb begin
		dec       = '0;
		dec.valid = 1'b1;
		unique case (REG_WDATA[3:0])
			fci_pkg::OP_READ: begin
				dec.rd1 = 1'b1;
			end
			fci_pkg::OP_READ_ARRAY: begin
				// RULE7: read-array selection
				dec.code1 = fci_pkg::CMD_READ_ARRAY;
			end
			fci_pkg::OP_READ_ID: begin
				// RULE10: identifier then read
				dec.code1 = fci_pkg::CMD_READ_ID;
				dec.two   = 1'b1;
				dec.rd2   = 1'b1;
			end
			fci_pkg::OP_READ_STATUS: begin
				// RULE12: status then read
				dec.code1 = fci_pkg::CMD_READ_STATUS;
				dec.two   = 1'b1;
				dec.rd2   = 1'b1;
			end
			fci_pkg::OP_CLR_STATUS: begin
				// RULE13: single clear write
				dec.code1 = fci_pkg::CMD_CLR_STATUS;
			end
			fci_pkg::OP_ERASE: begin
				// RULE14: setup then confirm
				dec.code1 = fci_pkg::CMD_ERASE_SETUP;
				dec.two   = 1'b1;
				dec.code2 = fci_pkg::CMD_CONFIRM;
			end
			fci_pkg::OP_PROGRAM: begin
				// RULE15: setup then data
				dec.code1 = fci_pkg::CMD_PROG_SETUP;
				dec.two   = 1'b1;
				dec.data2 = 1'b1;
			end
			fci_pkg::OP_SUSPEND: begin
				// RULE16: single suspend write
				dec.code1 = fci_pkg::CMD_SUSPEND;
			end
			fci_pkg::OP_RESUME: begin
				dec.code1 = fci_pkg::CMD_CONFIRM;
			end
			fci_pkg::OP_BLOCK_LOCK: begin
				// RULE19: block lock pair
				dec.code1 = fci_pkg::CMD_LOCK_SETUP;
				dec.two   = 1'b1;
				dec.code2 = fci_pkg::CMD_BLOCK_LOCK;
			end
			fci_pkg::OP_MASTER_LOCK: begin
				// RULE18: master lock pair
				dec.code1 = fci_pkg::CMD_LOCK_SETUP;
				dec.two   = 1'b1;
				dec.code2 = fci_pkg::CMD_MASTER_LOCK;
			end
			fci_pkg::OP_CLEAR_LOCKS: begin
				// RULE20: clear all locks pair
				dec.code1 = fci_pkg::CMD_LOCK_SETUP;
				dec.two   = 1'b1;
				dec.code2 = fci_pkg::CMD_CONFIRM;
			end
			default: begin
				dec.valid = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Request qualification
	// ----------------------------------------
	assign op_write   = REG_WR && (REG_ADDR == fci_pkg::REG_OP_OFS);
	assign pins_write = REG_WR && (REG_ADDR == fci_pkg::REG_PINS_OFS);
	assign stat_write = REG_WR && (REG_ADDR == fci_pkg::REG_STAT_OFS);
	// No command while the reset pin is low or still inside its wake interval
	assign rp_ok      = FL_RP_N && (wake_cnt == 8'h00) && !pd_req;
	// RULE9: supply level never gates a command
	assign accept     = op_write && dec.valid && (seq == fci_pkg::S_IDLE) && rp_ok;
	// A supply or reset-pin change mid-sequence would corrupt the confirm
	assign refuse_evt = (op_write && !accept) || (pins_write && (seq != fci_pkg::S_IDLE));

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			flash_addr <= fci_pkg::RST_ADDR;
			prog_data  <= fci_pkg::RST_DATA;
		end else begin
			if (REG_WR && (REG_ADDR == fci_pkg::REG_ADDR_OFS) && (seq == fci_pkg::S_IDLE)) begin
				flash_addr <= REG_WDATA[fci_pkg::ADDR_W-1:0];
			end
			if (REG_WR && (REG_ADDR == fci_pkg::REG_DATA_OFS) && (seq == fci_pkg::S_IDLE)) begin
				prog_data <= REG_WDATA[fci_pkg::DQ_W-1:0];
			end
		end
	end

	// RULE23: qualifiers frozen while a sequence runs
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			pd_req      <= 1'b0;
			FL_RP_HV_EN <= 1'b0;
			FL_VPP_EN   <= 1'b0;
		end else if (pins_write && (seq == fci_pkg::S_IDLE)) begin
			pd_req      <= REG_WDATA[fci_pkg::PINS_PD_BIT];
			// RULE17: high voltage for locked blocks
			FL_RP_HV_EN <= REG_WDATA[fci_pkg::PINS_HV_BIT];
			// RULE21: supply enable gates alteration
			FL_VPP_EN   <= REG_WDATA[fci_pkg::PINS_VPP_BIT];
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			refused <= 1'b0;
		end else if (refuse_evt) begin
			refused <= 1'b1;
		end else if (stat_write && REG_WDATA[fci_pkg::STAT_REFUSED_BIT]) begin
			refused <= 1'b0;
		end
	end

	// ----------------------------------------
	// Ready/busy synchroniser
	// ----------------------------------------
	// RULE6: busy pin observed, two stages
	// RULE8: software waits on busy
	always_ff @(posedge REF_CLK) begin
		ryby_s1 <= FL_READY_BUSY_N_N;
		ryby_s2 <= ryby_s1;
	end

	// ----------------------------------------
	// Deep power-down control
	// ----------------------------------------
	// RULE7: wake returns device to read-array
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			FL_RP_N  <= 1'b1;
			pd_cnt   <= 8'h00;
			wake_cnt <= 8'h00;
		end else if (FL_RP_N && pd_req && (seq == fci_pkg::S_IDLE)) begin
			FL_RP_N  <= 1'b0;
			pd_cnt   <= fci_pkg::PLPH_CYC - 8'h01;
			wake_cnt <= 8'h00;
		end else if (!FL_RP_N) begin
			if (pd_cnt != 8'h00) begin
				pd_cnt <= pd_cnt - 8'h01;
			end else if (!pd_req) begin
				FL_RP_N  <= 1'b1;
				wake_cnt <= fci_pkg::PHWL_CYC;
			end
		end else if (wake_cnt != 8'h00) begin
			wake_cnt <= wake_cnt - 8'h01;
		end
	end

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			seq          <= fci_pkg::S_IDLE;
			cur          <= '0;
			last_op      <= fci_pkg::RST_OP;
			rd_data      <= fci_pkg::RST_DATA;
			cyc.start    <= 1'b0;
			cyc.is_write <= 1'b0;
			cyc.addr     <= fci_pkg::RST_ADDR;
			cyc.wdata    <= fci_pkg::RST_DATA;
		end else begin
			cyc.start <= 1'b0;
			unique case (seq)
				fci_pkg::S_IDLE: begin
					if (accept) begin
						seq          <= fci_pkg::S_FIRST;
						cur          <= dec;
						last_op      <= REG_WDATA[3:0];
						cyc.start    <= 1'b1;
						cyc.is_write <= !dec.rd1;
						cyc.addr     <= flash_addr;
						cyc.wdata    <= dec.code1;
					end
				end
				fci_pkg::S_FIRST: begin
					if (cyc.done) begin
						if (cur.rd1) begin
							rd_data <= cyc.rdata;
						end
						if (cur.two) begin
							// RULE14: second write, same block address
							seq          <= fci_pkg::S_SECOND;
							cyc.start    <= 1'b1;
							cyc.is_write <= !cur.rd2;
							cyc.wdata    <= cur.data2 ? prog_data : cur.code2;
						end else begin
							seq <= fci_pkg::S_IDLE;
						end
					end
				end
				fci_pkg::S_SECOND: begin
					if (cyc.done) begin
						// RULE11: identifier byte returned to software
						if (cur.rd2) begin
							rd_data <= cyc.rdata;
						end
						seq <= fci_pkg::S_IDLE;
					end
				end
				default: begin
					seq <= fci_pkg::S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Register read-back
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			REG_RDATA <= 32'h00000000;
		end else if (REG_RD) begin
			case (REG_ADDR)
				fci_pkg::REG_ADDR_OFS: REG_RDATA <= 32'(flash_addr);
				fci_pkg::REG_DATA_OFS: REG_RDATA <= 32'(prog_data);
				fci_pkg::REG_OP_OFS:   REG_RDATA <= 32'(last_op);
				fci_pkg::REG_STAT_OFS: REG_RDATA <= {16'h0000, rd_data, 4'h0,
					!rp_ok, refused, ryby_s2, (seq != fci_pkg::S_IDLE)};
				fci_pkg::REG_PINS_OFS: REG_RDATA <= {29'h00000000, FL_VPP_EN,
					FL_RP_HV_EN, pd_req};
				default:               REG_RDATA <= 32'h00000000;
			endcase
		end else begin
			REG_RDATA <= 32'h00000000;
		end
	end

	// ----------------------------------------
	// Bus cycle engine
	// ----------------------------------------
	fci_cycle u_cycle (
		.clk   (REF_CLK),
		.rst   (SYS_RST),
		.bus   (cyc.eng),
		.ce_n  (FL_CE_N),
		.oe_n  (FL_OE_N),
		.we_n  (FL_WE_N),
		.addr  (FL_ADDR),
		.dq_o  (FL_DQ_O),
		.dq_oe (FL_DQ_OE),
		.dq_i  (FL_DQ_I)
	);

endmodule

// >>> verilog/fci_pkg.sv
// Overview of operation
// RULE1: Command write: WE and CE low, OE high.
// RULE2: Device latches on first rising strobe.
// RULE3: Device drives data only during reads.
// RULE4: OE high floats device data outputs.
// RULE5: CE high is standby; operations continue.
// RULE6: Ready/busy low while erase/program/lock runs.
// RULE7: Read-array after power-up, wake, or FFH.
// RULE8: Read-array ignored while operation runs unsuspended.
// RULE9: Read-array accepted at any supply level.
// RULE10: 90H selects identifier reads at ident_address.
// RULE11: Identifier gives per-block and master lock codes.
// RULE12: 70H makes every read return status.
// RULE13: 50H clears error flags, not when suspended.
// RULE14: Erase is 20H then D0H, same block.
// RULE15: Program is 40H/10H then address and data.
// RULE16: B0H suspends, D0H resumes, any address.
// RULE17: Locked block needs high voltage reset pin.
// RULE18: Master lock 60H F1H needs high voltage.
// RULE19: Block lock 60H 01H; master lock needs HV.
// RULE20: 60H D0H clears all locks; master needs HV.
// RULE21: Low program supply blocks alteration, reads stay.
// RULE22: Host issues only defined command codes.
// RULE23: Voltage qualifiers held stable at confirmation.
package fci_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int ADDR_W = 21;
	localparam int DQ_W   = 8;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	// Bus timing figures are plain defaults, to be set for the part in use
	localparam int CLK_PERIOD_NS = 40;
	localparam int SYNC_STAGES   = 2;
	localparam int T_SETUP_NS    = 40;
	localparam int T_WPULSE_NS   = 80;
	localparam int T_RACC_NS     = 160;
	localparam int T_HOLD_NS     = 40;
	localparam int T_PLPH_NS     = 120;
	localparam int T_PHWL_NS     = 1000;

	localparam logic [7:0] SETUP_CYC  = 8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] WPULSE_CYC = 8'((T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] RACC_CYC   =
		8'((T_RACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
	localparam logic [7:0] HOLD_CYC   = 8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] PLPH_CYC   = 8'((T_PLPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] PHWL_CYC   = 8'((T_PHWL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] REG_ADDR_OFS = 8'h00;
	localparam logic [7:0] REG_DATA_OFS = 8'h04;
	localparam logic [7:0] REG_OP_OFS   = 8'h08;
	localparam logic [7:0] REG_STAT_OFS = 8'h0C;
	localparam logic [7:0] REG_PINS_OFS = 8'h10;

	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_READY_BIT   = 1;
	localparam int STAT_REFUSED_BIT = 2;
	localparam int STAT_PWRDN_BIT   = 3;
	localparam int STAT_RDATA_LSB   = 8;
	localparam int PINS_PD_BIT      = 0;
	localparam int PINS_HV_BIT      = 1;
	localparam int PINS_VPP_BIT     = 2;

	localparam logic [ADDR_W-1:0] RST_ADDR = 21'h000000;
	localparam logic [DQ_W-1:0]   RST_DATA = 8'h00;
	localparam logic [3:0]        RST_OP   = 4'h0;

	// ----------------------------------------
	// Device command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
	localparam logic [7:0] CMD_READ_ID     = 8'h90;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
	localparam logic [7:0] CMD_PROG_SETUP  = 8'h40;
	localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
	localparam logic [7:0] CMD_LOCK_SETUP  = 8'h60;
	localparam logic [7:0] CMD_BLOCK_LOCK  = 8'h01;
	localparam logic [7:0] CMD_MASTER_LOCK = 8'hF1;

	// ----------------------------------------
	// Software operation codes
	// ----------------------------------------
	localparam logic [3:0] OP_READ         = 4'h0;
	localparam logic [3:0] OP_READ_ARRAY   = 4'h1;
	localparam logic [3:0] OP_READ_ID      = 4'h2;
	localparam logic [3:0] OP_READ_STATUS  = 4'h3;
	localparam logic [3:0] OP_CLR_STATUS   = 4'h4;
	localparam logic [3:0] OP_ERASE        = 4'h5;
	localparam logic [3:0] OP_PROGRAM      = 4'h6;
	localparam logic [3:0] OP_SUSPEND      = 4'h7;
	localparam logic [3:0] OP_RESUME       = 4'h8;
	localparam logic [3:0] OP_BLOCK_LOCK   = 4'h9;
	localparam logic [3:0] OP_MASTER_LOCK  = 4'hA;
	localparam logic [3:0] OP_CLEAR_LOCKS  = 4'hB;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic       valid;
		logic       rd1;
		logic       two;
		logic       rd2;
		logic       data2;
		logic [7:0] code1;
		logic [7:0] code2;
	} fci_op_s;

	typedef enum logic [1:0] {S_IDLE, S_FIRST, S_SECOND} fci_seq_e;
	typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fci_eng_e;

endpackage

// >>> verilog/fci_cyc_if.sv
`timescale 1ns/1ps
interface fci_cyc_if;
	logic                       start;
	logic                       is_write;
	logic [fci_pkg::ADDR_W-1:0] addr;
	logic [fci_pkg::DQ_W-1:0]   wdata;
	logic [fci_pkg::DQ_W-1:0]   rdata;
	logic                       done;

	modport ctl (output start, is_write, addr, wdata, input rdata, done);
	modport eng (input start, is_write, addr, wdata, output rdata, done);
endinterface

// >>> verilog/fci_cycle.sv
`timescale 1ns/1ps
module fci_cycle (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// Sequencer side
	fci_cyc_if.eng                          bus,
	// Flash bus pins
	output logic                            ce_n,
	output logic                            oe_n,
	output logic                            we_n,
	output logic [fci_pkg::ADDR_W-1:0]      addr,
	output logic [fci_pkg::DQ_W-1:0]        dq_o,
	output logic                            dq_oe,
	input  wire logic [fci_pkg::DQ_W-1:0]   dq_i
);

	fci_pkg::fci_eng_e        state;
	logic [7:0]               cnt;
	logic                     is_wr;
	logic [fci_pkg::DQ_W-1:0] dq_s1;
	logic [fci_pkg::DQ_W-1:0] dq_s2;

	// ----------------------------------------
	// Data input synchroniser
	// ----------------------------------------
	always_ff @(posedge clk) begin
		dq_s1 <= dq_i;
		dq_s2 <= dq_s1;
	end

	// ----------------------------------------
	// Strobe sequencing
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state     <= fci_pkg::E_IDLE;
			cnt       <= 8'h00;
			is_wr     <= 1'b0;
			ce_n      <= 1'b1;
			oe_n      <= 1'b1;
			we_n      <= 1'b1;
			addr      <= fci_pkg::RST_ADDR;
			dq_o      <= fci_pkg::RST_DATA;
			dq_oe     <= 1'b0;
			bus.rdata <= fci_pkg::RST_DATA;
			bus.done  <= 1'b0;
		end else begin
			bus.done <= 1'b0;
			unique case (state)
				fci_pkg::E_IDLE: begin
					if (bus.start) begin
						state <= fci_pkg::E_SETUP;
						cnt   <= fci_pkg::SETUP_CYC - 8'h01;
						is_wr <= bus.is_write;
						addr  <= bus.addr;
						dq_o  <= bus.wdata;
						ce_n  <= 1'b0;
						// RULE3: drive data only on writes
						dq_oe <= bus.is_write;
					end
				end
				fci_pkg::E_SETUP: begin
					if (cnt == 8'h00) begin
						state <= fci_pkg::E_STROBE;
						if (is_wr) begin
							// RULE1: WE low, OE held high
							cnt  <= fci_pkg::WPULSE_CYC - 8'h01;
							we_n <= 1'b0;
						end else begin
							cnt  <= fci_pkg::RACC_CYC - 8'h01;
							oe_n <= 1'b0;
						end
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				fci_pkg::E_STROBE: begin
					if (cnt == 8'h00) begin
						// RULE2: WE rises before CE
						state <= fci_pkg::E_HOLD;
						cnt   <= fci_pkg::HOLD_CYC - 8'h01;
						we_n  <= 1'b1;
						// RULE4: OE high floats device data
						oe_n  <= 1'b1;
						if (!is_wr) begin
							bus.rdata <= dq_s2;
						end
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				fci_pkg::E_HOLD: begin
					if (cnt == 8'h00) begin
						// RULE5: deselect returns device to standby
						state    <= fci_pkg::E_IDLE;
						ce_n     <= 1'b1;
						dq_oe    <= 1'b0;
						bus.done <= 1'b1;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
			endcase
		end
	end

endmodule

// >>> sim/fci_top_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// Flash bus checks
// ----------------------------------------
module fci_top_asserts (
	// Clock and reset
	input wire logic                       REF_CLK,
	input wire logic                       SYS_RST,
	// Flash bus
	input wire logic                       FL_CE_N,
	input wire logic                       FL_OE_N,
	input wire logic                       FL_WE_N,
	input wire logic [fci_pkg::ADDR_W-1:0] FL_ADDR,
	input wire logic [fci_pkg::DQ_W-1:0]   FL_DQ_O,
	input wire logic                       FL_DQ_OE,
	input wire logic                       FL_RP_HV_EN,
	input wire logic                       FL_VPP_EN
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	chk_write_select: assert property (
		!FL_WE_N |-> !FL_CE_N && FL_OE_N) else $error("write strobe without select");
	chk_we_width: assert property (
		$fell(FL_WE_N) |-> !FL_WE_N [*2] ##1 FL_WE_N) else $error("write pulse width");
	chk_we_first: assert property (
		$rose(FL_WE_N) |-> !FL_CE_N ##1 FL_CE_N) else $error("select rose before write");
	chk_addr_hold: assert property (
		!FL_CE_N && !$past(FL_CE_N) |-> $stable(FL_ADDR) && $stable(FL_DQ_O))
		else $error("address or data moved in cycle");
	chk_read_select: assert property (
		!FL_OE_N |-> !FL_CE_N && FL_WE_N && !FL_DQ_OE) else $error("read without select");
	chk_read_width: assert property (
		$fell(FL_OE_N) |-> !FL_OE_N [*6] ##1 FL_OE_N) else $error("read width");
	chk_cmd_gap: assert property (
		$rose(FL_CE_N) |-> FL_CE_N [*2]) else $error("cycles too close");
	chk_level_hold: assert property (
		!FL_CE_N |-> $stable(FL_RP_HV_EN) && $stable(FL_VPP_EN))
		else $error("qualifier moved in cycle");

	cover property ($fell(FL_WE_N));
	cover property ($fell(FL_OE_N));
	cover property (FL_DQ_OE && FL_RP_HV_EN);
endmodule

bind fci_top fci_top_asserts i_fci_top_asserts (.REF_CLK, .SYS_RST, .FL_CE_N, .FL_OE_N,
	.FL_WE_N, .FL_ADDR, .FL_DQ_O, .FL_DQ_OE, .FL_RP_HV_EN, .FL_VPP_EN);

// >>> sim/fci_flash_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Behavioural flash device
// ----------------------------------------
module fci_flash_model #(
	parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
	parameter logic [7:0] DEV_CODE   = 8'h5E, // Arbitrary value
	parameter int         BUSY_CYC   = 100
) (
	// Clock
	input  wire logic        clk,
	// Bus
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [20:0] addr,
	input  wire logic [7:0]  din,
	input  wire logic        din_oe,
	output logic [7:0]       dq,
	// Control
	input  wire logic        rp_n,
	input  wire logic        hv,
	input  wire logic        vpp,
	output logic             ready_busy_n_n
);
	logic [1:0]  mode;
	logic [7:0]  first, sr, last, val, cd, fail;
	logic [7:0]  mem [16];
	logic [31:0] locks;
	logic        mlock, susp;
	int          busy;
	wire  logic [4:0] blk = addr[20:16];

	initial begin
		{mode, first, sr, last, locks, mlock, susp} = '0;
		busy = 0;
		foreach (mem[i]) mem[i] = 8'hFF;
	end

	assign ready_busy_n_n = !(busy > 0 && !susp) || !rp_n;

	// running work continues while deselected; reset pin low aborts it, wake in array mode
	always @(posedge clk) begin
		last <= dq;
		if (!rp_n) begin
			{busy, mode, first, susp, sr} = '0;
		end else if (busy > 0 && !susp) begin
			busy = busy - 1;
		end
	end

	always @* begin
		case (mode)
			2'd1: val = (addr[1:0] == 2'd0) ? MAKER_CODE : (addr[1:0] == 2'd1) ? DEV_CODE :
				{7'h00, (addr[1:0] == 2'd2) ? locks[blk] : mlock};
			2'd2: val = {ready_busy_n_n, susp, sr[5:0]};
			default: val = mem[addr[3:0]];
		endcase
	end

	// drive only in a read; a floating bus keeps toggling
	assign dq = (!ce_n && !oe_n && we_n && rp_n) ? val : ~last;

	always @(posedge we_n or posedge ce_n) begin
		cd = din_oe ? din : ~last;
		if ((!we_n || !ce_n) && oe_n && rp_n) begin
			if (first != 8'h00) begin
				fail = 8'h30;
				if (first == 8'h40 || first == 8'h10)
					fail = (locks[blk] && !hv) ? 8'h12 : 8'h00;
				else if (first == 8'h20 && cd == 8'hD0)
					fail = (locks[blk] && !hv) ? 8'h22 : 8'h00;
				else if (first == 8'h60 && cd == 8'h01)
					fail = (mlock && !hv) ? 8'h12 : 8'h00;
				else if (first == 8'h60 && cd == 8'hF1)
					fail = hv ? 8'h00 : 8'h12;
				else if (first == 8'h60 && cd == 8'hD0)
					fail = (mlock && !hv) ? 8'h22 : 8'h00;
				if (!vpp && fail != 8'h30)
					fail = (first == 8'h20) ? 8'h28 : 8'h18;
				sr = sr | fail;
				if (fail == 8'h00) begin
					busy = BUSY_CYC;
					if (first == 8'h20)
						foreach (mem[i]) mem[i] = 8'hFF;
					else if (first == 8'h60 && cd == 8'h01)
						locks[blk] = 1'b1;
					else if (first == 8'h60 && cd == 8'hF1)
						mlock = 1'b1;
					else if (first == 8'h60)
						locks = '0;
					else
						mem[addr[3:0]] = mem[addr[3:0]] & cd;
				end
				first = 8'h00;
				mode = 2'd2;
			end else begin
				case (cd)
					8'hFF: if (busy == 0 || susp) mode = 2'd0;
					8'h90: mode = 2'd1;
					8'h70: mode = 2'd2;
					8'h50: if (!susp) sr = 8'h00;
					8'hB0: susp = busy > 0;
					8'hD0: susp = 1'b0;
					8'h20, 8'h40, 8'h10, 8'h60: first = cd;
					default: sr = sr | 8'h30;
				endcase
			end
		end
	end
endmodule

// >>> sim/fci_top_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Controller bench
// ----------------------------------------
module fci_top_tb;
	localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
	localparam logic [7:0] RA = fci_pkg::REG_ADDR_OFS;
	localparam logic [7:0] RD = fci_pkg::REG_DATA_OFS;
	localparam logic [7:0] ST = fci_pkg::REG_STAT_OFS;
	localparam logic [7:0] PN = fci_pkg::REG_PINS_OFS;
	logic        clk = 1'b0;
	logic        rst, wr, rd, ce_n, oe_n, we_n, dq_oe, rp_n, hv, vpp, ryby;
	logic [7:0]  ra, dq_o, dq_i;
	logic [31:0] rw, rdat;
	logic [20:0] fa;
	int          err_count, n_tests, cyc;

	always #20 clk = ~clk;

	fci_top i_fci_top (.REF_CLK(clk), .SYS_RST(rst), .REG_ADDR(ra), .REG_WDATA(rw),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .FL_CE_N(ce_n), .FL_OE_N(oe_n),
		.FL_WE_N(we_n), .FL_ADDR(fa), .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe), .FL_DQ_I(dq_i),
		.FL_RP_N(rp_n), .FL_RP_HV_EN(hv), .FL_VPP_EN(vpp), .FL_READY_BUSY_N_N(ryby));
	fci_flash_model #(.MAKER_CODE(MAKER)) i_fci_flash_model (.clk(clk), .ce_n(ce_n),
		.oe_n(oe_n), .we_n(we_n), .addr(fa), .din(dq_o), .din_oe(dq_oe), .dq(dq_i),
		.rp_n(rp_n), .hv(hv), .vpp(vpp), .ready_busy_n_n(ryby));

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		ra <= a;
		rw <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		ra <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdat;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	// Polls status until the chosen bit reaches the wanted level
	task automatic poll(input int b, input logic v);
		logic [31:0] s;
		repeat (200) begin
			rreg(ST, s);
			if (s[b] === v) break;
		end
		chk("poll", {7'h00, v}, {7'h00, s[b]});
	endtask

	task automatic op(input logic [3:0] c);
		wreg(fci_pkg::REG_OP_OFS, {28'h0, c});
		poll(0, 1'b0);
	endtask

	task automatic rd_op(input logic [3:0] c, input logic [20:0] a, input logic [7:0] e,
		input string n);
		logic [31:0] s;
		wreg(RA, {11'h0, a});
		op(c);
		rreg(ST, s);
		chk(n, e, s[15:8]);
	endtask

	task automatic t_reset;
		logic [31:0] s;
		rreg(fci_pkg::REG_OP_OFS, s);
		chk("op reg", {4'h0, fci_pkg::RST_OP}, s[7:0]);
		rreg(8'h14, s);
		chk("unmapped", 8'h00, s[7:0]);
		rd_op(fci_pkg::OP_READ, 21'h5, 8'hFF, "power-up read");
		$display("test reset done");
	endtask

	task automatic t_ident;
		rd_op(fci_pkg::OP_READ_ID, 21'h0, MAKER, "maker code");
		rd_op(fci_pkg::OP_READ_ID, 21'h3, 8'h00, "master code");
		$display("test ident done");
	endtask

	task automatic t_program;
		logic [31:0] s;
		wreg(PN, 32'h4);
		wreg(RA, 32'h5);
		wreg(RD, 32'hA5);
		op(fci_pkg::OP_PROGRAM);
		poll(1, 1'b1);
		rd_op(fci_pkg::OP_READ_STATUS, 21'h5, 8'h80, "prog status");
		op(fci_pkg::OP_READ_ARRAY);
		rd_op(fci_pkg::OP_READ, 21'h5, 8'hA5, "prog data");
		op(fci_pkg::OP_ERASE);
		op(fci_pkg::OP_READ_ARRAY);
		rd_op(fci_pkg::OP_READ, 21'h5, 8'h00, "busy read");
		op(fci_pkg::OP_SUSPEND);
		op(fci_pkg::OP_READ_ARRAY);
		rd_op(fci_pkg::OP_READ, 21'h5, 8'hFF, "suspended read");
		rreg(ST, s);
		chk("suspend ready", 8'h01, {7'h00, s[1]});
		op(fci_pkg::OP_RESUME);
		poll(1, 1'b1);
		rd_op(fci_pkg::OP_READ_STATUS, 21'h5, 8'h80, "erase status");
		$display("test program done");
	endtask

	task automatic t_lock;
		op(fci_pkg::OP_BLOCK_LOCK);
		poll(1, 1'b1);
		rd_op(fci_pkg::OP_READ_ID, 21'h2, 8'h01, "block code");
		wreg(RD, 32'h0);
		op(fci_pkg::OP_PROGRAM);
		rd_op(fci_pkg::OP_READ_STATUS, 21'h5, 8'h92, "locked prog");
		op(fci_pkg::OP_CLR_STATUS);
		op(fci_pkg::OP_MASTER_LOCK);
		rd_op(fci_pkg::OP_READ_STATUS, 21'h5, 8'h92, "master low");
		wreg(PN, 32'h6);
		op(fci_pkg::OP_PROGRAM);
		poll(1, 1'b1);
		op(fci_pkg::OP_CLR_STATUS);
		rd_op(fci_pkg::OP_READ_STATUS, 21'h5, 8'h80, "cleared");
		op(fci_pkg::OP_READ_ARRAY);
		rd_op(fci_pkg::OP_READ, 21'h5, 8'h00, "hv prog");
		op(fci_pkg::OP_CLEAR_LOCKS);
		poll(1, 1'b1);
		rd_op(fci_pkg::OP_READ_ID, 21'h2, 8'h00, "locks gone");
		wreg(PN, 32'h0);
		op(fci_pkg::OP_PROGRAM);
		rd_op(fci_pkg::OP_READ_STATUS, 21'h5, 8'h98, "low supply");
		$display("test lock done");
	endtask

	// Undefined codes set the refused flag; a status write clears it
	task automatic t_refuse;
		logic [31:0] s;
		op(4'hC);
		rreg(ST, s);
		chk("refused", 8'h01, {7'h00, s[2]});
		wreg(ST, 32'h4);
		rreg(ST, s);
		chk("refused clear", 8'h00, {7'h00, s[2]});
		$display("test refuse done");
	endtask

	task automatic t_pdown;
		logic [31:0] s;
		wreg(PN, 32'h1);
		rreg(ST, s);
		chk("pd held", 8'h01, {7'h00, s[3]});
		wreg(PN, 32'h0);
		poll(3, 1'b0);
		rd_op(fci_pkg::OP_READ, 21'h5, 8'h00, "wake read");
		$display("test pdown done");
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Whole run needs under two thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			tally_and_finish();
		end
	end

	initial begin
		{ra, rw, wr, rd} = '0;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_ident();
		t_program();
		t_lock();
		t_refuse();
		t_pdown();
		tally_and_finish();
	end
endmodule
